// ==== rtl/timer2_pkg.sv ====
// Constants, register map and mode type for the capture/reload timer
package timer2_pkg;

  // Special-function addresses
  localparam logic [7:0] CTRL_ADDR = 8'hc8;
  localparam logic [7:0] CAP_LOW_ADDR = 8'hca;
  localparam logic [7:0] CAP_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] CNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] CNT_HIGH_ADDR = 8'hcd;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Control register fields
  localparam int OVF_BIT = 7;
  localparam int EXT_BIT = 6;
  localparam int RX_BAUD_BIT = 5;
  localparam int TX_BAUD_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam int CP_RL_BIT = 0;

  // Count limits and timer prescale
  localparam logic [15:0] COUNT_WRAP = 16'hffff;
  localparam int TIMER_DIV_DEFAULT = 12;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_RELOAD,
    MODE_BAUD
  } mode_e;

endpackage : timer2_pkg

// ==== rtl/pin_edge_if.sv ====
// Falling-edge pulses of the external pins, shared between modules
`timescale 1ns/1ps
interface pin_edge_if;
  logic count_fall;
  logic trig_fall;
  modport src (output count_fall, output trig_fall);
  modport dst (input count_fall, input trig_fall);
endinterface : pin_edge_if

// ==== rtl/pin_edges.sv ====
// Falling-edge detection on the count and trigger pins
`timescale 1ns/1ps
module pin_edges
  import timer2_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic count_pin,
  input wire logic ext_trigger_pin,
  // Edge pulses
  pin_edge_if.src edges
);

  logic count_ff;
  logic trig_ff;

  // Previous pin levels, idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= 1'b1;
      trig_ff <= 1'b1;
    end else begin
      count_ff <= count_pin;
      trig_ff <= ext_trigger_pin;
    end
  end

  assign edges.count_fall = count_ff && !count_pin;
  assign edges.trig_fall = trig_ff && !ext_trigger_pin;

endmodule : pin_edges

// ==== rtl/timer2_capture_reload.sv ====
// Sixteen-bit timer/counter with capture, auto-reload and baud modes
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Count source bit picks timer or counter
// RULE2: Capture, reload and baud modes from control
// RULE3: Capture mode counts sixteen bits, flags overflow
// RULE4: Trigger fall copies count into capture pair
// RULE5: Trigger fall sets external event flag
// RULE6: Either flag raises the single interrupt
// RULE7: Flags cleared only by firmware writes
// RULE8: Reload mode wrap sets flag, loads capture
// RULE9: Reload mode trigger fall also reloads
// RULE10: Reload mode counts upward only
// RULE11: Control at C8h, resets 00h, fixed fields
// RULE12: Capture/reload bit set means capture mode
// RULE13: Count advances only while run bit set
module timer2_capture_reload
  import timer2_pkg::*;
#(
  parameter int TIMER_DIV = TIMER_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Special-function bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // External pins
  input wire logic count_pin,
  input wire logic ext_trigger_pin,
  // Core side outputs
  output logic irq,
  output logic baud_tick
);

  localparam int PRE_W = $clog2(TIMER_DIV + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TIMER_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  pin_edge_if edges ();

  pin_edges u_pin_edges (
    .clk(clk),
    .rst(rst),
    .count_pin(count_pin),
    .ext_trigger_pin(ext_trigger_pin),
    .edges(edges)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] timer2_control_reg;
  logic [7:0] nxt_ctrl;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] cap_ff;
  logic [15:0] nxt_cap;
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic irq_ff;
  logic baud_tick_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  wire run_control = timer2_control_reg[RUN_BIT];
  wire count_source_select = timer2_control_reg[SRC_BIT];
  wire ext_trigger_enable = timer2_control_reg[EXT_EN_BIT];
  wire capture_reload_select = timer2_control_reg[CP_RL_BIT];
  wire tx_baud_select = timer2_control_reg[TX_BAUD_BIT];
  wire rx_baud_select = timer2_control_reg[RX_BAUD_BIT];
  wire overflow_flag = timer2_control_reg[OVF_BIT];
  wire ext_event_flag = timer2_control_reg[EXT_BIT];

  mode_e mode;
  // Mode select
  assign mode = (rx_baud_select || tx_baud_select) ? MODE_BAUD :  // RULE2
                capture_reload_select ? MODE_CAPTURE :              // RULE12
                MODE_RELOAD;

  ////////////////////////////////////////////////////////////////////////////
  // Count events
  wire pre_tick = run_control && (pre_ff == PRE_LAST);
  // Timer ticks or pin edges
  wire inc = run_control &&                                          // RULE13
             (count_source_select ? edges.count_fall : pre_tick);    // RULE1
  wire wrap = inc && (count_ff == COUNT_WRAP);
  wire trig = ext_trigger_enable && edges.trig_fall;
  wire do_capture = (mode == MODE_CAPTURE) && trig;                  // RULE4
  wire do_reload = (mode != MODE_CAPTURE) &&
                   (wrap || (trig && mode == MODE_RELOAD));          // RULE8
  wire set_ovf = wrap && (mode != MODE_BAUD);                        // RULE3
  wire set_ext = trig;                                               // RULE5

  // Bus decode
  wire wr_ctrl = sfr_wr && hit(sfr_addr, CTRL_ADDR);                 // RULE11
  wire wr_cnt_lo = sfr_wr && hit(sfr_addr, CNT_LOW_ADDR);
  wire wr_cnt_hi = sfr_wr && hit(sfr_addr, CNT_HIGH_ADDR);
  wire wr_cap_lo = sfr_wr && hit(sfr_addr, CAP_LOW_ADDR);
  wire wr_cap_hi = sfr_wr && hit(sfr_addr, CAP_HIGH_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  assign nxt_pre = !run_control ? pre_ff :
                   pre_tick ? PRE_ZERO : pre_ff + PRE_W'(1);

  // Counter: firmware write, then reload, then upward step
  wire [15:0] count_step = do_reload ? cap_ff :                      // RULE9
                           inc ? count_ff + 16'h0001 : count_ff;     // RULE10
  assign nxt_count = {wr_cnt_hi ? sfr_wdata : count_step[15:8],
                      wr_cnt_lo ? sfr_wdata : count_step[7:0]};

  // Capture pair: hardware capture wins over a firmware preset
  assign nxt_cap = do_capture ? count_ff :
                   {wr_cap_hi ? sfr_wdata : cap_ff[15:8],
                    wr_cap_lo ? sfr_wdata : cap_ff[7:0]};

  // Flags: hardware set wins over firmware clear
  wire [7:0] ctrl_base = wr_ctrl ? sfr_wdata : timer2_control_reg;   // RULE7
  assign nxt_ctrl = {ctrl_base[OVF_BIT] | set_ovf,
                     ctrl_base[EXT_BIT] | set_ext,
                     ctrl_base[5:0]};

  // Read mux, one cycle latency
  assign nxt_rdata = hit(sfr_addr, CTRL_ADDR) ? timer2_control_reg :
                     hit(sfr_addr, CNT_LOW_ADDR) ? count_ff[7:0] :
                     hit(sfr_addr, CNT_HIGH_ADDR) ? count_ff[15:8] :
                     hit(sfr_addr, CAP_LOW_ADDR) ? cap_ff[7:0] :
                     hit(sfr_addr, CAP_HIGH_ADDR) ? cap_ff[15:8] :
                     RDATA_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      timer2_control_reg <= CTRL_RESET;                              // RULE11
      count_ff <= COUNT_RESET;
      cap_ff <= CAP_RESET;
      pre_ff <= PRE_ZERO;
    end else begin
      timer2_control_reg <= nxt_ctrl;
      count_ff <= nxt_count;
      cap_ff <= nxt_cap;
      pre_ff <= nxt_pre;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
      baud_tick_ff <= 1'b0;
      rdata_ff <= RDATA_RESET;
    end else begin
      irq_ff <= nxt_ctrl[OVF_BIT] | nxt_ctrl[EXT_BIT];               // RULE6
      baud_tick_ff <= wrap && (mode == MODE_BAUD);
      rdata_ff <= nxt_rdata;
    end
  end

  assign irq = irq_ff;
  assign baud_tick = baud_tick_ff;
  assign sfr_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_src_counter: assert property ( // RULE1
    run_control && count_source_select && !edges.count_fall &&
    !sfr_wr && !trig |=> count_ff == $past(count_ff))
    else $error("counter moved without a pin edge");

  chk_baud_no_flag: assert property ( // RULE2
    mode == MODE_BAUD && !wr_ctrl |=> !$rose(overflow_flag))
    else $error("overflow flag set in baud mode");

  chk_wrap_flag: assert property ( // RULE3
    inc && count_ff == COUNT_WRAP && mode == MODE_CAPTURE && !sfr_wr
    |=> overflow_flag && count_ff == 16'h0000)
    else $error("capture mode wrap not flagged");

  chk_capture_copy: assert property ( // RULE4
    do_capture |=> cap_ff == $past(count_ff))
    else $error("capture pair missed the count");

  chk_capture_flag: assert property ( // RULE5
    trig ##1 !$past(sfr_wr) |-> ext_event_flag)
    else $error("trigger edge did not set event flag");

  chk_irq_flags: assert property ( // RULE6
    irq == (overflow_flag || ext_event_flag))
    else $error("interrupt not equal to flag or");

  chk_flags_sticky: assert property ( // RULE7
    overflow_flag && !wr_ctrl |=> overflow_flag)
    else $error("overflow flag cleared by hardware");

  chk_event_sticky: assert property ( // RULE7
    ext_event_flag && !wr_ctrl |=> ext_event_flag)
    else $error("event flag cleared by hardware");

  chk_reload_wrap: assert property ( // RULE8
    wrap && mode == MODE_RELOAD && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(cap_ff) && overflow_flag)
    else $error("reload on wrap failed");

  chk_reload_trig: assert property ( // RULE9
    trig && mode == MODE_RELOAD && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(cap_ff))
    else $error("reload on trigger failed");

  chk_count_up: assert property ( // RULE10
    inc && !do_reload && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("count did not step up by one");

  chk_ctrl_read: assert property ( // RULE11
    sfr_addr == CTRL_ADDR |=> sfr_rdata == $past(timer2_control_reg))
    else $error("control read returned wrong value");

  chk_mode_sel: assert property ( // RULE12
    !rx_baud_select && !tx_baud_select
    |-> (mode == MODE_CAPTURE) == capture_reload_select)
    else $error("capture/reload select misdecoded");

  chk_run_hold: assert property ( // RULE13
    (!run_control && !sfr_wr && !trig) [*2]
    |-> count_ff == $past(count_ff))
    else $error("count moved while stopped");

  chk_reset_state: assert property ( // RULE11
    disable iff (1'b0) rst |=> timer2_control_reg == CTRL_RESET &&
    count_ff == COUNT_RESET && cap_ff == CAP_RESET && !irq &&
    !baud_tick && sfr_rdata == RDATA_RESET)
    else $error("state after reset is wrong");

  chk_unmapped_read: assert property ( // RULE11
    sfr_addr != CTRL_ADDR && sfr_addr != CNT_LOW_ADDR &&
    sfr_addr != CNT_HIGH_ADDR && sfr_addr != CAP_LOW_ADDR &&
    sfr_addr != CAP_HIGH_ADDR |=> sfr_rdata == RDATA_RESET)
    else $error("unmapped read did not return zero");

  chk_ctrl_write: assert property ( // RULE11
    wr_ctrl |=> timer2_control_reg[5:0] == $past(sfr_wdata[5:0]))
    else $error("control write did not land");

  chk_count_write: assert property ( // RULE11
    wr_cnt_hi |=> count_ff[15:8] == $past(sfr_wdata))
    else $error("count high write did not land");

  chk_trig_disabled: assert property ( // RULE5
    !ext_trigger_enable && !wr_ctrl |=> !$rose(ext_event_flag))
    else $error("event flag set with trigger disabled");

  chk_ovf_only_wrap: assert property ( // RULE3
    !wrap && !wr_ctrl |=> !$rose(overflow_flag))
    else $error("overflow flag set without a wrap");

  chk_capture_count: assert property ( // RULE4
    do_capture && !inc && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(count_ff))
    else $error("capture disturbed the count");

  chk_cap_hold: assert property ( // RULE4
    !do_capture && !wr_cap_lo && !wr_cap_hi |=> cap_ff == $past(cap_ff))
    else $error("capture pair changed by itself");

  chk_event_only_trig: assert property ( // RULE5
    !trig && !wr_ctrl |=> !$rose(ext_event_flag))
    else $error("event flag set without a trigger");

  chk_cap_preset: assert property ( // RULE8
    wr_cap_lo && !do_capture |=> cap_ff[7:0] == $past(sfr_wdata))
    else $error("capture preset write did not land");

  chk_baud_tick_src: assert property ( // RULE2
    wrap && mode == MODE_BAUD |=> baud_tick)
    else $error("baud wrap gave no tick");

  chk_baud_reload: assert property ( // RULE2
    wrap && mode == MODE_BAUD && !wr_cnt_lo && !wr_cnt_hi
    |=> count_ff == $past(cap_ff))
    else $error("baud wrap did not reload");

  chk_prescale_hold: assert property ( // RULE13
    !run_control |=> pre_ff == $past(pre_ff))
    else $error("prescaler moved while stopped");

  cov_reload_trig: cover property (trig && mode == MODE_RELOAD);
  cov_capture: cover property (do_capture ##1 irq);
  cov_reload_wrap: cover property (wrap && mode == MODE_RELOAD);
  cov_counter_mode: cover property (inc && count_source_select);
  cov_baud_tick: cover property (baud_tick);

endmodule : timer2_capture_reload

// ==== bench/pin_partner.sv ====
// Pin driver standing in for the external count and trigger sources
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input wire logic clk,
  // Pulse requests from the bench
  input wire logic cnt_req,
  input wire logic trg_req,
  // Pins, idle high
  output logic count_pin,
  output logic ext_trigger_pin
);
  // One-clock low pulse gives one falling edge
  always @(posedge clk) begin
    count_pin <= ~cnt_req;
    ext_trigger_pin <= ~trg_req;
  end
endmodule : pin_partner

// ==== bench/timer2_capture_reload_tb.sv ====
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module timer2_capture_reload_tb
  import timer2_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic count_pin;
  logic ext_trigger_pin;
  logic irq;
  logic baud_tick;
  logic cnt_req = 1'b0;
  logic trg_req = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] b;
  logic [15:0] v;
  logic [15:0] v2;
  logic seen;
  // Rows: address, write data, expected read
  logic [23:0] rows [6] = '{
    {CAP_LOW_ADDR, 8'h5a, 8'h5a}, {CAP_HIGH_ADDR, 8'ha5, 8'ha5},
    {CNT_LOW_ADDR, 8'h3c, 8'h3c}, {CNT_HIGH_ADDR, 8'hc3, 8'hc3},
    {8'h80, 8'h77, 8'h00}, {CTRL_ADDR, 8'h01, 8'h01}};

  timer2_capture_reload #(.TIMER_DIV(1)) timer2_capture_reload_i (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .count_pin(count_pin),
    .ext_trigger_pin(ext_trigger_pin), .irq(irq), .baud_tick(baud_tick));

  pin_partner pin_partner_i (
    .clk(clk), .cnt_req(cnt_req), .trg_req(trg_req),
    .count_pin(count_pin), .ext_trigger_pin(ext_trigger_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask : rd

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    d = {hi, lo};
  endtask : rd16

  task automatic pulse(input logic trg);
    @(posedge clk);
    if (trg) trg_req <= 1'b1;
    else cnt_req <= 1'b1;
    @(posedge clk);
    trg_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, b);
    check("ctrl_reset", 16'h0000, {8'h00, b});
    check("irq_reset", 16'h0000, {15'h0, irq});
    rd16(CNT_LOW_ADDR, v);
    check("count_reset", 16'h0000, v);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], b);
      check("reg_table", {8'h00, rows[i][7:0]}, {8'h00, b});
    end
    // Timer mode runs, then holds
    wr(CTRL_ADDR, 8'h05);
    repeat (10) @(posedge clk);
    wr(CTRL_ADDR, 8'h01);
    rd16(CNT_LOW_ADDR, v);
    check("timer_moved", 16'hc348, v);
    repeat (10) @(posedge clk);
    rd16(CNT_LOW_ADDR, v2);
    check("timer_held", v, v2);
    // Counter mode wrap
    wr(CNT_LOW_ADDR, 8'hfe);
    wr(CNT_HIGH_ADDR, 8'hff);
    wr(CTRL_ADDR, 8'h07);
    pulse(1'b0);
    pulse(1'b0);
    rd16(CNT_LOW_ADDR, v);
    check("count_wrap", 16'h0000, v);
    rd(CTRL_ADDR, b);
    check("ovf_flag", 16'h0087, {8'h00, b});
    check("irq_ovf", 16'h0001, {15'h0, irq});
    repeat (50) @(posedge clk);
    rd(CTRL_ADDR, b);
    check("flag_kept", 16'h0087, {8'h00, b});
    wr(CTRL_ADDR, 8'h07);
    rd(CTRL_ADDR, b);
    check("flag_clr", 16'h0007, {8'h00, b});
    check("irq_clr", 16'h0000, {15'h0, irq});
    // Capture on trigger
    wr(CNT_LOW_ADDR, 8'h34);
    wr(CNT_HIGH_ADDR, 8'h12);
    wr(CTRL_ADDR, 8'h0b);
    pulse(1'b1);
    rd16(CAP_LOW_ADDR, v);
    check("capture", 16'h1234, v);
    rd16(CNT_LOW_ADDR, v);
    check("count_kept", 16'h1234, v);
    rd(CTRL_ADDR, b);
    check("ext_flag", 16'h004b, {8'h00, b});
    check("irq_ext", 16'h0001, {15'h0, irq});
    // Reload mode
    wr(CTRL_ADDR, 8'h0e);
    wr(CNT_LOW_ADDR, 8'hff);
    wr(CNT_HIGH_ADDR, 8'hff);
    pulse(1'b0);
    rd16(CNT_LOW_ADDR, v);
    check("reload_wrap", 16'h1234, v);
    rd(CTRL_ADDR, b);
    check("reload_ovf", 16'h008e, {8'h00, b});
    pulse(1'b0);
    rd16(CNT_LOW_ADDR, v);
    check("count_up", 16'h1235, v);
    pulse(1'b1);
    rd16(CNT_LOW_ADDR, v);
    check("reload_trig", 16'h1234, v);
    rd(CTRL_ADDR, b);
    check("reload_ext", 16'h00ce, {8'h00, b});
    // Baud mode tick from either baud select, no overflow flag
    for (int m = 0; m < 2; m++) begin
      v2 = m ? 16'h0024 : 16'h0014;
      wr(CTRL_ADDR, 8'h00);
      wr(CNT_LOW_ADDR, 8'hff);
      wr(CNT_HIGH_ADDR, 8'hff);
      wr(CTRL_ADDR, v2[7:0]);
      seen = 1'b0;
      repeat (20) begin
        @(posedge clk);
        #1 if (baud_tick === 1'b1) seen = 1'b1;
      end
      check("baud_tick", 16'h0001, {15'h0, seen});
      rd(CTRL_ADDR, b);
      check("baud_ctrl", v2, {8'h00, b});
    end
    // Reset with the run bit clear and both flags raised
    wr(CTRL_ADDR, 8'hc0);
    rd(CTRL_ADDR, b);
    check("ctrl_fw_set", 16'h00c0, {8'h00, b});
    check("irq_fw_set", 16'h0001, {15'h0, irq});
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, b);
    check("ctrl_rst", 16'h0000, {8'h00, b});
    check("irq_rst", 16'h0000, {15'h0, irq});
    rd16(CNT_LOW_ADDR, v);
    check("count_rst", 16'h0000, v);
    rd16(CAP_LOW_ADDR, v);
    check("cap_rst", 16'h0000, v);
    test_done();
  end
endmodule : timer2_capture_reload_tb
